// File: hdl/bbu_pkg.sv
// constants, opcodes and types for the boolean and branch execution unit
package bbu_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  // core clocks per machine cycle; every instruction needs at most 8 clocks
  // of work and a one-cycle form at most 6, so values below 6 would stretch the one-cycle forms
  localparam int MC_CLOCKS_DEFAULT = 12;

  // ==========================================================================
  // opcodes
  // ==========================================================================
  localparam logic [7:0] OPC_IDLE = 8'h00;
  localparam logic [7:0] OPC_FAR_BRANCH = 8'h02;
  localparam logic [7:0] OPC_FAR_CALL = 8'h12;
  localparam logic [7:0] OPC_SUB_EXIT = 8'h22;
  localparam logic [7:0] OPC_INT_EXIT = 8'h32;
  localparam logic [7:0] OPC_SHORT_REL = 8'h80;
  localparam logic [7:0] OPC_IND_BRANCH = 8'h73;
  localparam logic [7:0] OPC_ACC_ZERO = 8'h60;
  localparam logic [7:0] OPC_ACC_NZ = 8'h70;
  localparam logic [7:0] OPC_CARRY = 8'h40;
  localparam logic [7:0] OPC_NO_CARRY = 8'h50;
  localparam logic [7:0] OPC_BIT_SET = 8'h20;
  localparam logic [7:0] OPC_BIT_CLEAR = 8'h30;
  localparam logic [7:0] OPC_TEST_CLR = 8'h10;
  localparam logic [7:0] OPC_CMP_DIR = 8'hB5;
  localparam logic [7:0] OPC_CMP_IMM = 8'hB4;
  localparam logic [7:0] OPC_CMP_IND = 8'hB6;
  localparam logic [7:0] OPC_CMP_REG = 8'hB8;
  localparam logic [7:0] OPC_DEC_REG = 8'hD8;
  localparam logic [7:0] OPC_DEC_DIR = 8'hD5;
  localparam logic [7:0] OPC_CLR_C = 8'hC3;
  localparam logic [7:0] OPC_CLR_BIT = 8'hC2;
  localparam logic [7:0] OPC_SET_C = 8'hD3;
  localparam logic [7:0] OPC_SET_BIT = 8'hD2;
  localparam logic [7:0] OPC_INV_C = 8'hB3;
  localparam logic [7:0] OPC_INV_BIT = 8'hB2;
  localparam logic [7:0] OPC_AND_BIT = 8'h82;
  localparam logic [7:0] OPC_AND_NBIT = 8'hB0;
  localparam logic [7:0] OPC_OR_BIT = 8'h72;
  localparam logic [7:0] OPC_OR_NBIT = 8'hA0;
  localparam logic [7:0] OPC_LOAD_C = 8'hA2;
  localparam logic [7:0] OPC_STORE_C = 8'h92;
  localparam logic [7:0] OPC_LOAD_WREG_DIR = 8'hE5;

  // ==========================================================================
  // opcode fields and address layout
  // ==========================================================================
  localparam logic [7:0] PAGE_MASK = 8'h1F;
  localparam logic [7:0] PAGE_BRANCH_LOW = 8'h01;
  localparam logic [7:0] PAGE_CALL_LOW = 8'h11;
  localparam logic [7:0] REG_MASK = 8'hF8;
  localparam logic [7:0] IND_MASK = 8'hFE;
  localparam logic [7:0] WREG_DIRECT_ADDR = 8'hE0;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] BIT_SFR_MASK = 8'hF8;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [7:0] SP_PAIR = 8'h02;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [2:0] {
    RD_NONE, RD_DIR, RD_BIT, RD_REG, RD_IND, RD_STACK
  } bbu_rd_t;

  // gray codes along fetch, operands, prep, pointer, read, exec, push, pop, wait
  typedef enum logic [3:0] {
    S_FETCH = 4'h0,
    S_OPND1 = 4'h1,
    S_OPND2 = 4'h3,
    S_PREP = 4'h2,
    S_PTR = 4'h6,
    S_READ = 4'h7,
    S_EXEC = 4'h5,
    S_PUSH = 4'h4,
    S_POP = 4'hC,
    S_WAIT = 4'hD
  } bbu_state_t;

endpackage

// File: hdl/bbu_bit_logic.sv
// carry and direct-bit operations on one addressed byte
module bbu_bit_logic
  import bbu_pkg::*;
(
  input wire logic [7:0] opc_i,
  input wire logic carry_i,
  input wire logic [7:0] byte_i,
  input wire logic [2:0] bit_idx_i,
  output logic bit_val_o,
  output logic next_carry_o,
  output logic [7:0] next_byte_o
);

  logic new_bit;

  // ==========================================================================
  // carry and new bit value
  // ==========================================================================
  assign bit_val_o = byte_i[bit_idx_i];

  // carry result; ops that do not target carry leave it as it was
  always_comb begin
    next_carry_o = carry_i;
    new_bit = bit_val_o;
    case (opc_i)
      OPC_AND_BIT: next_carry_o = carry_i & bit_val_o;
      OPC_AND_NBIT: next_carry_o = carry_i & ~bit_val_o;
      OPC_OR_BIT: next_carry_o = carry_i | bit_val_o;
      OPC_OR_NBIT: next_carry_o = carry_i | ~bit_val_o;
      OPC_LOAD_C: next_carry_o = bit_val_o;
      OPC_STORE_C: new_bit = carry_i;
      OPC_CLR_BIT: new_bit = 1'b0;
      OPC_SET_BIT: new_bit = 1'b1;
      OPC_INV_BIT: new_bit = ~bit_val_o;
      OPC_TEST_CLR: new_bit = 1'b0;
      default: new_bit = bit_val_o;
    endcase
  end

  // ==========================================================================
  // byte merge: only the addressed bit may change
  // ==========================================================================
  for (genvar i = 0; i < 8; i++) begin : g_merge
    assign next_byte_o[i] = (bit_idx_i == 3'(i)) ? new_bit : byte_i[i];
  end

endmodule

// File: hdl/bbu_branch_unit.sv
// boolean and program-control instruction sequencer
module bbu_branch_unit
  import bbu_pkg::*;
#(
  parameter int CLK_PER_MC = MC_CLOCKS_DEFAULT
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] code_byte_i,
  input wire logic code_valid_i,
  input wire logic [7:0] work_reg_i,
  input wire logic [15:0] data_pointer_i,
  input wire logic [1:0] bank_i,
  input wire logic [7:0] mem_rdata_i,
  output logic code_rd_o,
  output logic [15:0] code_addr_o,
  output logic [7:0] mem_addr_o,
  output logic mem_ind_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  output logic carry_o,
  output logic [7:0] sp_o,
  output logic instr_done_o,
  output logic irq_exit_o,
  output logic undefined_o,
  output logic unhandled_o
);

  localparam logic [7:0] MC_CLKS = 8'(CLK_PER_MC);

  bbu_state_t state;
  logic [7:0] opc, op1, op2, tmp, dec_opc, dec_val, bu_byte, need_m1;
  logic [7:0] cyc, bit_byte_addr;
  logic [15:0] pc, rel1_tgt, rel2_tgt, call_tgt;
  logic [1:0] len;
  logic two_mc, known, bu_bit, bu_carry, stalled;
  logic is_page_br, is_page_call, is_cmp_reg, is_dec_reg, is_cmp_ind;
  bbu_rd_t rd_sel;

  assign code_addr_o = pc;

  // ==========================================================================
  // decode: length, machine cycles and operand read kind
  // ==========================================================================
  // the opcode is decoded from the bus while it is being taken
  assign dec_opc = (state == S_FETCH) ? code_byte_i : opc;
  assign is_page_br = (dec_opc & PAGE_MASK) == PAGE_BRANCH_LOW;
  assign is_page_call = (dec_opc & PAGE_MASK) == PAGE_CALL_LOW;
  assign is_cmp_reg = (dec_opc & REG_MASK) == OPC_CMP_REG;
  assign is_dec_reg = (dec_opc & REG_MASK) == OPC_DEC_REG;
  assign is_cmp_ind = (dec_opc & IND_MASK) == OPC_CMP_IND;

  always_comb begin
    len = LEN_ONE;
    two_mc = 1'b1;
    rd_sel = RD_NONE;
    known = 1'b1;
    if (is_page_br || is_page_call) begin
      len = LEN_TWO;
    end else if (is_cmp_reg) begin
      len = LEN_THREE;
      rd_sel = RD_REG;
    end else if (is_dec_reg) begin
      len = LEN_TWO;
      rd_sel = RD_REG;
    end else if (is_cmp_ind) begin
      len = LEN_THREE;
      rd_sel = RD_IND;
    end else begin
      case (dec_opc)
        OPC_IDLE, OPC_CLR_C, OPC_SET_C, OPC_INV_C: two_mc = 1'b0;
        OPC_CLR_BIT, OPC_SET_BIT, OPC_INV_BIT, OPC_LOAD_C: begin
          len = LEN_TWO;
          two_mc = 1'b0;
          rd_sel = RD_BIT;
        end
        OPC_AND_BIT, OPC_AND_NBIT, OPC_OR_BIT, OPC_OR_NBIT,
        OPC_STORE_C: begin
          len = LEN_TWO;
          rd_sel = RD_BIT;
        end
        OPC_FAR_BRANCH, OPC_FAR_CALL, OPC_CMP_IMM: len = LEN_THREE;
        OPC_SUB_EXIT, OPC_INT_EXIT: rd_sel = RD_STACK;
        OPC_IND_BRANCH: len = LEN_ONE;
        OPC_SHORT_REL, OPC_ACC_ZERO, OPC_ACC_NZ, OPC_CARRY,
        OPC_NO_CARRY: len = LEN_TWO;
        OPC_BIT_SET, OPC_BIT_CLEAR, OPC_TEST_CLR: begin
          len = LEN_THREE;
          rd_sel = RD_BIT;
        end
        OPC_CMP_DIR, OPC_DEC_DIR: begin
          len = LEN_THREE;
          rd_sel = RD_DIR;
        end
        OPC_LOAD_WREG_DIR: begin
          len = LEN_TWO;
          two_mc = 1'b0;
        end
        default: begin
          // other groups belong to other units: step over one byte
          two_mc = 1'b0;
          known = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // addresses and targets
  // ==========================================================================
  assign bit_byte_addr = op1[7] ? (op1 & BIT_SFR_MASK)
                                : (BIT_AREA_BASE | {4'h0, op1[6:3]});
  assign rel1_tgt = pc + {{8{op1[7]}}, op1};
  assign rel2_tgt = pc + {{8{op2[7]}}, op2};
  assign call_tgt = is_page_call ? {pc[15:11], opc[7:5], op1} : {op1, op2};
  assign dec_val = tmp - SP_STEP;
  assign need_m1 = two_mc ? MC_CLKS + MC_CLKS - 8'h01 : MC_CLKS - 8'h01;

  bbu_bit_logic u_bit (
    .opc_i(opc),
    .carry_i(carry_o),
    .byte_i(tmp),
    .bit_idx_i(op1[2:0]),
    .bit_val_o(bu_bit),
    .next_carry_o(bu_carry),
    .next_byte_o(bu_byte)
  );

  // ==========================================================================
  // machine-cycle timing
  // ==========================================================================
  // clocks since the opcode fetch began; the wait state pads each
  // instruction out to its whole number of machine cycles
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cyc <= 8'h00;
    end else if (state == S_WAIT && cyc >= need_m1) begin
      cyc <= 8'h00;
    end else if (cyc != 8'hFF) begin
      cyc <= cyc + 8'h01;
    end
  end

  // a slow code memory stretches the instruction past its budget
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stalled <= 1'b0;
    end else if (state == S_WAIT && cyc >= need_m1) begin
      stalled <= 1'b0;
    end else if (cyc >= need_m1 && state != S_WAIT) begin
      // flag the overrun one edge early so the budget check sees it in time
      stalled <= 1'b1;
    end
  end

  // ==========================================================================
  // sequencer and datapath
  // ==========================================================================
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= S_FETCH;
      pc <= PC_RESET;
      opc <= OPC_IDLE;
      op1 <= 8'h00;
      op2 <= 8'h00;
      tmp <= 8'h00;
      carry_o <= 1'b0;
      sp_o <= SP_RESET;
      code_rd_o <= 1'b1;
      mem_addr_o <= 8'h00;
      mem_ind_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= 8'h00;
      instr_done_o <= 1'b0;
      irq_exit_o <= 1'b0;
      undefined_o <= 1'b0;
      unhandled_o <= 1'b0;
    end else begin
      // strobes last one cycle unless a state raises them again
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      instr_done_o <= 1'b0;
      irq_exit_o <= 1'b0;
      undefined_o <= 1'b0;
      unhandled_o <= 1'b0;
      case (state)
        S_FETCH: if (code_valid_i) begin
          opc <= code_byte_i;
          pc <= pc + PC_STEP;
          unhandled_o <= ~known;
          if (len == LEN_ONE) begin
            code_rd_o <= 1'b0;
            state <= S_PREP;
          end else begin
            state <= S_OPND1;
          end
        end
        S_OPND1: if (code_valid_i) begin
          op1 <= code_byte_i;
          pc <= pc + PC_STEP;
          if (len == LEN_THREE) begin
            state <= S_OPND2;
          end else begin
            code_rd_o <= 1'b0;
            state <= S_PREP;
          end
        end
        S_OPND2: if (code_valid_i) begin
          op2 <= code_byte_i;
          pc <= pc + PC_STEP;
          code_rd_o <= 1'b0;
          state <= S_PREP;
        end
        S_PREP: begin
          mem_ind_o <= (rd_sel == RD_STACK);
          mem_rd_o <= (rd_sel != RD_NONE);
          state <= S_READ;
          if (rd_sel == RD_STACK) begin
            mem_addr_o <= sp_o;
          end else if (rd_sel == RD_BIT) begin
            mem_addr_o <= bit_byte_addr;
          end else if (rd_sel == RD_DIR) begin
            mem_addr_o <= op1;
          end else if (rd_sel == RD_REG) begin
            mem_addr_o <= {3'h0, bank_i, opc[2:0]};
          end else if (rd_sel == RD_IND) begin
            mem_addr_o <= {3'h0, bank_i, 2'h0, opc[0]};
            state <= S_PTR;
          end else begin
            state <= S_EXEC;
          end
        end
        S_PTR: begin
          // pointer register read; now fetch the byte it points at
          mem_addr_o <= mem_rdata_i;
          mem_ind_o <= 1'b1;
          mem_rd_o <= 1'b1;
          state <= S_READ;
        end
        S_READ: begin
          tmp <= mem_rdata_i;
          if (rd_sel == RD_STACK) begin
            mem_addr_o <= sp_o - SP_STEP;
            mem_rd_o <= 1'b1;
            state <= S_POP;
          end else begin
            state <= S_EXEC;
          end
        end
        S_POP: begin
          pc <= {tmp, mem_rdata_i};
          sp_o <= sp_o - SP_PAIR;
          irq_exit_o <= (opc == OPC_INT_EXIT);
          state <= S_WAIT;
        end
        S_EXEC: begin
          state <= S_WAIT;
          if (is_page_call || opc == OPC_FAR_CALL) begin
            mem_addr_o <= sp_o + SP_STEP;
            mem_ind_o <= 1'b1;
            mem_wdata_o <= pc[7:0];
            mem_wr_o <= 1'b1;
            state <= S_PUSH;
          end else if (is_page_br) begin
            pc <= {pc[15:11], opc[7:5], op1};
          end else if (is_cmp_reg || is_cmp_ind) begin
            carry_o <= tmp < op1;
            if (tmp != op1) pc <= rel2_tgt;
          end else if (is_dec_reg) begin
            mem_wdata_o <= dec_val;
            mem_wr_o <= 1'b1;
            if (dec_val != 8'h00) pc <= rel1_tgt;
          end else begin
            case (opc)
              OPC_CLR_C: carry_o <= 1'b0;
              OPC_SET_C: carry_o <= 1'b1;
              OPC_INV_C: carry_o <= ~carry_o;
              OPC_AND_BIT, OPC_AND_NBIT, OPC_OR_BIT, OPC_OR_NBIT,
              OPC_LOAD_C: carry_o <= bu_carry;
              OPC_CLR_BIT, OPC_SET_BIT, OPC_INV_BIT, OPC_STORE_C: begin
                mem_wdata_o <= bu_byte;
                mem_wr_o <= 1'b1;
              end
              OPC_IND_BRANCH: pc <= data_pointer_i + {8'h00, work_reg_i};
              OPC_FAR_BRANCH: pc <= {op1, op2};
              OPC_SHORT_REL: pc <= rel1_tgt;
              OPC_ACC_ZERO: if (work_reg_i == 8'h00) pc <= rel1_tgt;
              OPC_ACC_NZ: if (work_reg_i != 8'h00) pc <= rel1_tgt;
              OPC_CARRY: if (carry_o) pc <= rel1_tgt;
              OPC_NO_CARRY: if (!carry_o) pc <= rel1_tgt;
              OPC_BIT_SET: if (bu_bit) pc <= rel2_tgt;
              OPC_BIT_CLEAR: if (!bu_bit) pc <= rel2_tgt;
              OPC_TEST_CLR: if (bu_bit) begin
                pc <= rel2_tgt;
                mem_wdata_o <= bu_byte;
                mem_wr_o <= 1'b1;
              end
              OPC_CMP_DIR: begin
                carry_o <= work_reg_i < tmp;
                if (work_reg_i != tmp) pc <= rel2_tgt;
              end
              OPC_CMP_IMM: begin
                carry_o <= work_reg_i < op1;
                if (work_reg_i != op1) pc <= rel2_tgt;
              end
              OPC_DEC_DIR: begin
                mem_wdata_o <= dec_val;
                mem_wr_o <= 1'b1;
                if (dec_val != 8'h00) pc <= rel2_tgt;
              end
              OPC_LOAD_WREG_DIR: undefined_o <= (op1 == WREG_DIRECT_ADDR);
              default: ;
            endcase
          end
        end
        S_PUSH: begin
          mem_addr_o <= sp_o + SP_PAIR;
          mem_wdata_o <= pc[15:8];
          mem_wr_o <= 1'b1;
          sp_o <= sp_o + SP_PAIR;
          pc <= call_tgt;
          state <= S_WAIT;
        end
        S_WAIT: if (cyc >= need_m1) begin
          instr_done_o <= 1'b1;
          code_rd_o <= 1'b1;
          state <= S_FETCH;
        end
        default: state <= S_FETCH;
      endcase
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_cycle_budget:
    assert property (instr_done_o && !$past(stalled)
      |-> $past(cyc) == $past(need_m1))
    else $error("instruction did not take its machine cycles");
  a_and_carry:
    assert property (state == S_EXEC && opc == OPC_AND_BIT
      |=> carry_o == ($past(carry_o) && $past(bu_bit)))
    else $error("and into carry wrong");
  a_or_inverted:
    assert property (state == S_EXEC && opc == OPC_OR_NBIT
      |=> carry_o == ($past(carry_o) || !$past(bu_bit)) && !mem_wr_o)
    else $error("or of inverted bit wrong");
  a_zero_branch:
    assert property (state == S_EXEC && opc == OPC_ACC_ZERO
      |=> pc == ($past(work_reg_i) == 8'h00 ? $past(rel1_tgt) : $past(pc)))
    else $error("zero branch target wrong");
  a_indirect_jump:
    assert property (state == S_EXEC && opc == OPC_IND_BRANCH
      |=> pc == $past(data_pointer_i) + {8'h00, $past(work_reg_i)})
    else $error("computed jump target wrong");
  a_test_clear:
    assert property (state == S_EXEC && opc == OPC_TEST_CLR && bu_bit
      |=> mem_wr_o && !mem_wdata_o[op1[2:0]] && pc == $past(rel2_tgt))
    else $error("test and clear failed");
  a_decrement_loop:
    assert property (state == S_EXEC && opc == OPC_DEC_DIR
      |=> mem_wr_o && mem_wdata_o == $past(tmp) - 8'h01)
    else $error("decrement writeback wrong");
  a_undef_inert:
    assert property (state == S_EXEC && opc == OPC_LOAD_WREG_DIR
      && op1 == WREG_DIRECT_ADDR
      |=> undefined_o && !mem_wr_o && $stable(carry_o) && $stable(pc))
    else $error("undefined copy had an effect");
  a_call_push:
    assert property (state == S_EXEC && opc == OPC_FAR_CALL
      |=> mem_wr_o ##1 mem_wr_o && sp_o == $past(sp_o, 2) + SP_PAIR
      && pc == {op1, op2})
    else $error("call push sequence wrong");
  a_exit_restore:
    assert property (state == S_POP
      |=> pc == {$past(tmp), $past(mem_rdata_i)}
      && sp_o == $past(sp_o) - SP_PAIR)
    else $error("return address not restored");

endmodule

// File: verif/bbu_mem_model.sv
// program and data memory model standing behind the branch unit
module bbu_mem_model (
  input wire logic ref_clk_i,
  input wire logic code_rd_i,
  input wire logic [15:0] code_addr_i,
  output logic [7:0] code_byte_o,
  output logic code_valid_o,
  input wire logic [7:0] mem_addr_i,
  input wire logic mem_ind_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rom [65536];
  logic [7:0] ram [512];
  logic [8:0] da;
  initial begin
    foreach (rom[i]) rom[i] = 8'h00;
    foreach (ram[i]) ram[i] = 8'h00;
  end
  // lower 128 bytes are shared by both spaces
  assign da = {mem_ind_i & mem_addr_i[7], mem_addr_i};
  // idle lines show the inverse so a stale byte never passes as good
  assign code_valid_o = code_rd_i;
  assign code_byte_o = code_rd_i ? rom[code_addr_i] : ~rom[code_addr_i];
  assign mem_rdata_o = mem_rd_i ? ram[da] : ~ram[da];
  always @(posedge ref_clk_i) begin
    if (mem_wr_i) ram[da] <= mem_wdata_i;
  end
endmodule

// File: verif/test_bbu_branch_unit.sv
// self-checking bench for the boolean and branch unit
module test_bbu_branch_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import bbu_pkg::*;
  localparam int MC = 8;
  logic ref_clk_i, reset_n_i, code_valid_i, code_rd_o, mem_ind_o;
  logic mem_rd_o, mem_wr_o, carry_o, instr_done_o, undefined_o, c, useen;
  logic irq_exit_o, unhandled_o, iseen, hseen;
  logic [7:0] code_byte_i, work_reg_i, mem_rdata_i, mem_addr_o;
  logic [7:0] mem_wdata_o, sp_o;
  logic [15:0] data_pointer_i, code_addr_o, pc, sv;
  logic [1:0] bank_i;
  logic [31:0] seed, r;
  int errors, compares, cnt, last;
  bbu_branch_unit #(.CLK_PER_MC(MC)) dut (.ref_clk_i, .reset_n_i,
    .code_byte_i, .code_valid_i, .work_reg_i, .data_pointer_i, .bank_i,
    .mem_rdata_i, .code_rd_o, .code_addr_o, .mem_addr_o, .mem_ind_o,
    .mem_rd_o, .mem_wr_o, .mem_wdata_o, .carry_o, .sp_o, .instr_done_o,
    .irq_exit_o, .undefined_o, .unhandled_o);
  bbu_mem_model m (.ref_clk_i, .code_rd_i(code_rd_o),
    .code_addr_i(code_addr_o), .code_byte_o(code_byte_i),
    .code_valid_o(code_valid_i), .mem_addr_i(mem_addr_o),
    .mem_ind_i(mem_ind_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
  always #2 ref_clk_i = ~ref_clk_i;
  // cycle count doubles as the hang limit
  always @(posedge ref_clk_i) begin
    cnt++;
    if (undefined_o === 1'b1) useen <= 1'b1;
    if (irq_exit_o === 1'b1) iseen <= 1'b1;
    if (unhandled_o === 1'b1) hseen <= 1'b1;
    if (cnt == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] nx(int n);
    return pc + 16'(n);
  endfunction
  // target of a relative branch, offset sign-extended from next address
  function automatic logic [15:0] br(logic t, int n, logic [7:0] o);
    return t ? pc + 16'(n) + {{8{o[7]}}, o} : pc + 16'(n);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // loads one instruction at pc, waits for it, checks next pc, and checks time when cyc is nonzero
  task automatic exec(input logic [7:0] b0, b1, b2, input int cyc,
    input logic [15:0] nxt);
    int k;
    k = 0;
    m.rom[pc] = b0;
    m.rom[pc + 16'h1] = b1;
    m.rom[pc + 16'h2] = b2;
    @(negedge ref_clk_i);
    while (instr_done_o !== 1'b1 && k < 64) begin
      @(negedge ref_clk_i);
      k++;
    end
    if (cyc > 0) chk(16'(cnt - last), 16'(cyc * MC));
    chk(code_addr_o, nxt);
    last = cnt;
    pc = nxt;
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0; reset_n_i = 1'b0; work_reg_i = 8'h00; bank_i = 2'h0;
    data_pointer_i = 16'h0; seed = 32'h562f; pc = 16'h0; useen = 1'b0;
    iseen = 1'b0;
    hseen = 1'b0;
    errors = 0; compares = 0; cnt = 0; last = 0;
    repeat (4) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    m.ram[9'h021] = 8'h01;
    exec(OPC_IDLE, 8'h00, 8'h00, 0, nx(1));
    exec(OPC_SET_C, 8'h00, 8'h00, 1, nx(1));
    exec(OPC_AND_BIT, 8'h08, 8'h00, 2, nx(2)); chk(carry_o, 1'b1);
    exec(OPC_AND_NBIT, 8'h08, 8'h00, 2, nx(2)); chk(carry_o, 1'b0);
    exec(OPC_OR_BIT, 8'h08, 8'h00, 2, nx(2)); chk(carry_o, 1'b1);
    exec(OPC_CLR_C, 8'h00, 8'h00, 1, nx(1)); chk(carry_o, 1'b0);
    exec(OPC_OR_NBIT, 8'h08, 8'h00, 2, nx(2)); chk(carry_o, 1'b0);
    chk(m.ram[9'h021], 8'h01);
    exec(OPC_LOAD_C, 8'h08, 8'h00, 1, nx(2)); chk(carry_o, 1'b1);
    exec(OPC_CLR_BIT, 8'h08, 8'h00, 1, nx(2));
    exec(OPC_STORE_C, 8'h09, 8'h00, 2, nx(2)); chk(m.ram[9'h021], 8'h02);
    exec(OPC_BIT_CLEAR, 8'h08, 8'hF0, 2, br(1'b1, 3, 8'hF0));
    exec(OPC_TEST_CLR, 8'h09, 8'h10, 2, br(1'b1, 3, 8'h10));
    exec(OPC_TEST_CLR, 8'h09, 8'h10, 2, nx(3)); chk(m.ram[9'h021], 8'h00);
    // random offsets and operands, zero forced on half the draws
    for (int i = 0; i < 24; i++) begin
      r = xs();
      work_reg_i = r[8] ? 8'h00 : r[7:0];
      exec(OPC_ACC_ZERO, r[23:16], 8'h00, 2, br(work_reg_i == 0, 2, r[23:16]));
      exec(OPC_ACC_NZ, r[23:16], 8'h00, 2, br(work_reg_i != 0, 2, r[23:16]));
      exec(OPC_CMP_IMM, r[15:8], r[23:16], 2, br(r[15:8] != work_reg_i, 3, r[23:16]));
      c = work_reg_i < r[15:8];
      exec(OPC_CARRY, r[31:24], 8'h00, 2, br(c, 2, r[31:24]));
      exec(OPC_NO_CARRY, r[31:24], 8'h00, 2, br(!c, 2, r[31:24]));
      exec(OPC_SHORT_REL, r[31:24], 8'h00, 2, br(1'b1, 2, r[31:24]));
    end
    m.ram[9'h040] = 8'h01;
    exec(OPC_CMP_DIR, 8'h40, 8'h20, 2, br(work_reg_i != 1, 3, 8'h20));
    exec(OPC_DEC_DIR, 8'h40, 8'h20, 2, nx(3)); chk(m.ram[9'h040], 8'h00);
    exec(OPC_DEC_REG | 8'h03, 8'h05, 8'h00, 2, br(1'b1, 2, 8'h05));
    chk(m.ram[9'h003], 8'hFF);
    sv = nx(3);
    exec(OPC_FAR_CALL, 8'h12, 8'h34, 2, 16'h1234); chk(sp_o, 8'h09);
    exec(OPC_SUB_EXIT, 8'h00, 8'h00, 2, sv); chk(sp_o, 8'h07);
    chk(iseen, 1'b0);
    work_reg_i = 8'h05;
    data_pointer_i = 16'h2000;
    exec(OPC_IND_BRANCH, 8'h00, 8'h00, 2, 16'h2005);
    exec(OPC_LOAD_WREG_DIR, 8'hE0, 8'h00, 0, nx(2)); chk(useen, 1'b1);
    // corner cases: bit set and invert, bit-set branch, carry invert
    exec(OPC_SET_BIT, 8'h12, 8'h00, 1, nx(2));
    exec(OPC_INV_BIT, 8'h13, 8'h00, 1, nx(2));
    chk(m.ram[9'h022], 8'h0C);
    exec(OPC_BIT_SET, 8'h13, 8'h7F, 2, br(1'b1, 3, 8'h7F));
    exec(OPC_CLR_C, 8'h00, 8'h00, 1, nx(1));
    exec(OPC_INV_C, 8'h00, 8'h00, 1, nx(1));
    chk(carry_o, 1'b1);
    // page call with interrupt exit, then page and far branches
    sv = nx(2);
    exec(PAGE_CALL_LOW | 8'h20, 8'h20, 8'h00, 2,
      (sv & 16'hF800) | 16'h0120);
    chk(sp_o, 8'h09);
    exec(OPC_INT_EXIT, 8'h00, 8'h00, 2, sv);
    chk(iseen, 1'b1);
    chk(sp_o, 8'h07);
    exec(PAGE_BRANCH_LOW | 8'hE0, 8'h55, 8'h00, 2,
      (nx(2) & 16'hF800) | 16'h0755);
    exec(OPC_FAR_BRANCH, 8'hAB, 8'hCD, 2, 16'hABCD);
    // bank register and indirect compare forms, bank one selected
    bank_i = 2'h1;
    m.ram[9'h00A] = 8'h33;
    exec(OPC_CMP_REG | 8'h02, 8'h33, 8'h40, 2, nx(3));
    chk(carry_o, 1'b0);
    exec(OPC_CMP_REG | 8'h02, 8'h34, 8'h40, 2, br(1'b1, 3, 8'h40));
    chk(carry_o, 1'b1);
    m.ram[9'h008] = 8'h90;
    m.ram[9'h190] = 8'h5A;
    exec(OPC_CMP_IND, 8'h5A, 8'h10, 2, nx(3));
    chk(carry_o, 1'b0);
    exec(OPC_CMP_IND, 8'h5B, 8'h10, 2, br(1'b1, 3, 8'h10));
    chk(carry_o, 1'b1);
    // an opcode of another group is stepped over and flagged
    chk(hseen, 1'b0);
    exec(8'h04, 8'h00, 8'h00, 1, nx(1));
    chk(hseen, 1'b1);
    tally_and_finish();
  end
endmodule
